// >>> design/pci_cond_consts.svh
// Register offsets, field positions, reset values and select codes
`ifndef PCI_COND_CONSTS_SVH
`define PCI_COND_CONSTS_SVH

`define ACCEPT_HIGH_IDX 12'h342
`define SELECT_LOW_IDX 12'h344
`define ACCEPT_HIGH_ADDR (`ACCEPT_HIGH_IDX * 12'h004)
`define SELECT_LOW_ADDR (`SELECT_LOW_IDX * 12'h004)
`define REG_RESET 16'h0000
`define HI_RSVD_POS 11
`define SOFTWARE_TERMINATION_BIT_POS 7
`define GEN_COUNT 3'h4

`define SRC_ZERO 5'h00
`define SRC_GEN_MUX 5'h01
`define SRC_TRIG_A 5'h02
`define SRC_TRIG_B 5'h03
`define SRC_REMAP_FIRST 5'h08
`define SRC_REMAP_LAST 5'h12
`define SRC_PIN_FIRST 5'h13
`define SRC_PIN_LAST 5'h16
`define SRC_EVT_FIRST 5'h17
`define SRC_EVT_LAST 5'h1A
`define SRC_CMP_FIRST 5'h1B
`define SRC_CMP_LAST 5'h1D
`define SRC_CLC_ONE 5'h1F

`define QUAL_SW_ONLY 3'h7
`define SWM_ACCEPT 2'h0
`define SWM_AQUAL 2'h1
`define SWM_TQUAL 2'h2

`endif

// >>> design/pci_cond_pkg.sv
// Types of the PWM control input conditioner
package pci_cond_pkg;

    typedef struct packed {
        logic bypass_enable;
        logic [2:0] bypass_source;
        logic rsvd;
        logic [2:0] acceptance_criteria;
        logic software_control_bit;
        logic [1:0] software_control_mode;
        logic latch_dominance_mode;
        logic termination_qualifier_polarity;
        logic [2:0] termination_qualifier_selector;
    } accept_high_t;

    typedef struct packed {
        logic termination_sync_disable;
        logic [2:0] termination_event;
        logic acceptance_qualifier_polarity;
        logic [2:0] acceptance_qualifier_selector;
        logic software_termination_bit;
        logic source_sync;
        logic source_polarity;
        logic [4:0] source_selector;
    } select_low_t;

    typedef struct packed {
        logic gen_out_mux;
        logic trigger_a;
        logic trigger_b;
        logic trigger_c;
        logic [18:8] remap;
        logic [22:19] pins;
        logic [26:23] events;
        logic [29:27] comparators;
        logic clc_one;
        logic duty_active;
        logic blank_active;
        logic gen_triggered;
    } pci_sources_t;

    typedef enum logic [2:0] {
        ACC_LEVEL = 3'h0,
        ACC_RISE = 3'h1,
        ACC_ANY = 3'h2,
        ACC_LATCH = 3'h3,
        ACC_LATCH_RISE = 3'h4,
        ACC_LATCH_ANY = 3'h5
    } accept_crit_t;

    typedef enum logic [2:0] {
        LS_IDLE = 3'b001,
        LS_HELD = 3'b010,
        LS_WAIT = 3'b100
    } latch_state_t;

endpackage

// >>> design/pci_conditioner.sv
// PWM control input conditioner: registers, source selection, bypass
//
// Contract
// R1 - Source codes 0..3: zero, mux, triggers A/B
// R2 - Codes 8..18 remap inputs, 19..22 pins
// R3 - Events A-D, comparators 1-3, logic cell one
// R4 - Bypass enable takes another generator's output
// R5 - Bypass source code n picks generator n+1
// R6 - Absent bypass generator forces output zero
// R7 - Acceptance criteria codes 000..101, rest reserved
// R8 - Software bit drives its value where designated
// R9 - Mode 00 acceptance, 01 acceptance qualifier, 10 termination
// R10 - Latch reset-dominant when mode bit set
// R11 - Termination qualifier polarity inverts when set
// R12 - Termination qualifier codes; 111 software only
// R13 - Sync disable: terminate now, else at cycle end
// R14 - Termination event choices incl. auto terminate
// R15 - Manual termination only by software write
// R16 - Acceptance qualifier polarity inverts when set
// R17 - Software termination write pulses, reads zero
// R18 - Source sync samples source at cycle end
// R19 - Source polarity inverts selected source
// R20 - Acceptance qualifier shares termination qualifier codes
// R21 - Termination event codes in descending order
// R22 - Accept with qualifier; latch clears on qualified termination
// R23 - All fields reset to zero
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "pci_cond_consts.svh"
module pci_conditioner
    import pci_cond_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pci_sources_t sources,
    input wire logic eoc,
    input wire logic [3:0] bypass_in,
    output logic local_out,
    output logic pci_out
);
    ////////////////////////////////////////////////////////////////////////////
    accept_high_t hi_q;
    select_low_t lo_q;
    logic term_write_q;
    logic [31:0] prdata_q;
    logic src_hold_q;
    logic pci_out_q;
    logic hit_hi;
    logic hit_lo;
    logic wr_en;
    logic src_raw;
    logic src_sel;
    logic src_eff;
    logic aq;
    logic tq;
    logic term_evt;
    logic auto_term;
    logic bypass_valid;

    function automatic logic pick_source(input logic [4:0] sel, input pci_sources_t s);
        pick_source = 1'b0; // R1
        if (sel == `SRC_GEN_MUX) begin
            pick_source = s.gen_out_mux; // R1
        end else if (sel == `SRC_TRIG_A) begin
            pick_source = s.trigger_a;
        end else if (sel == `SRC_TRIG_B) begin
            pick_source = s.trigger_b;
        end else if (sel >= `SRC_REMAP_FIRST && sel <= `SRC_REMAP_LAST) begin
            pick_source = s.remap[sel]; // R2
        end else if (sel >= `SRC_PIN_FIRST && sel <= `SRC_PIN_LAST) begin
            pick_source = s.pins[sel]; // R2
        end else if (sel >= `SRC_EVT_FIRST && sel <= `SRC_EVT_LAST) begin
            pick_source = s.events[sel]; // R3
        end else if (sel >= `SRC_CMP_FIRST && sel <= `SRC_CMP_LAST) begin
            pick_source = s.comparators[sel]; // R3
        end else if (sel == `SRC_CLC_ONE) begin
            pick_source = s.clc_one; // R3
        end
    endfunction

    // Shared qualifier encoding, with polarity and software override
    function automatic logic qualify(input logic [2:0] sel, input logic pol,
                                     input logic sw, input pci_sources_t s);
        logic q;
        q = 1'b0;
        case (sel)
            3'h0: q = 1'b1; // R12 R20
            3'h1: q = s.duty_active;
            3'h2: q = s.blank_active;
            3'h3: q = s.gen_triggered;
            3'h4: q = s.gen_out_mux;
            3'h5: q = s.remap[8];
            3'h6: q = s.remap[9];
            default: q = 1'b0;
        endcase
        if (sel != `QUAL_SW_ONLY) q = q ^ pol; // R11 R16
        qualify = q | sw; // R8
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    assign hit_hi = (paddr == `ACCEPT_HIGH_ADDR);
    assign hit_lo = (paddr == `SELECT_LOW_ADDR);
    assign wr_en = psel & penable & pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~(hit_hi | hit_lo);
    assign prdata = prdata_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            hi_q <= accept_high_t'(`REG_RESET); // R23
            lo_q <= select_low_t'(`REG_RESET); // R23
        end else if (wr_en) begin
            if (hit_hi) begin
                if (pstrb[0]) hi_q[7:0] <= pwdata[7:0];
                if (pstrb[1]) hi_q[15:8] <= pwdata[15:8];
                hi_q[`HI_RSVD_POS] <= 1'b0;
            end else if (hit_lo) begin
                if (pstrb[0]) lo_q[7:0] <= pwdata[7:0];
                if (pstrb[1]) lo_q[15:8] <= pwdata[15:8];
                lo_q[`SOFTWARE_TERMINATION_BIT_POS] <= 1'b0; // R17
            end
        end
    end

    // Software termination is a write-only strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            term_write_q <= 1'b0;
        end else begin
            term_write_q <= wr_en & hit_lo & pstrb[0] & pwdata[`SOFTWARE_TERMINATION_BIT_POS]; // R17
        end
    end

    // Read data captured in the setup phase
    always_ff @(posedge clk) begin
        if (srst) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable) begin
            if (hit_hi) begin
                prdata_q <= {16'h0000, hi_q};
            end else if (hit_lo) begin
                prdata_q <= {16'h0000, lo_q};
            end else begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source path
    assign src_raw = pick_source(lo_q.source_selector, sources);

    always_ff @(posedge clk) begin
        if (srst) begin
            src_hold_q <= 1'b0;
        end else if (eoc) begin
            src_hold_q <= src_raw; // R18
        end
    end

    assign src_sel = lo_q.source_sync ? src_hold_q : src_raw; // R18
    assign src_eff = (src_sel ^ lo_q.source_polarity) | // R19
                     (hi_q.software_control_bit && hi_q.software_control_mode == `SWM_ACCEPT);
    assign aq = qualify(lo_q.acceptance_qualifier_selector, // R9 R16
                        lo_q.acceptance_qualifier_polarity,
                        hi_q.software_control_bit &&
                        hi_q.software_control_mode == `SWM_AQUAL, sources);
    assign tq = qualify(hi_q.termination_qualifier_selector, // R9 R11
                        hi_q.termination_qualifier_polarity,
                        hi_q.software_control_bit &&
                        hi_q.software_control_mode == `SWM_TQUAL, sources);

    always_comb begin
        term_evt = 1'b0;
        auto_term = 1'b0;
        case (lo_q.termination_event)
            3'h7: term_evt = sources.remap[9]; // R21
            3'h6: term_evt = sources.remap[8];
            3'h5: term_evt = sources.gen_out_mux;
            3'h4: term_evt = sources.trigger_c;
            3'h3: term_evt = sources.trigger_b;
            3'h2: term_evt = sources.trigger_a;
            3'h1: auto_term = 1'b1; // R14
            default: term_evt = term_write_q; // R15
        endcase
    end

    pci_latch_core u_core (
        .clk(clk),
        .srst(srst),
        .eoc(eoc),
        .src(src_eff),
        .aq(aq),
        .tq(tq),
        .term_evt(term_evt),
        .auto_term(auto_term),
        .criteria(hi_q.acceptance_criteria),
        .reset_dominant(hi_q.latch_dominance_mode),
        .sync_disable(lo_q.termination_sync_disable),
        .out_q(local_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bypass to another generator's conditioned input
    assign bypass_valid = hi_q.bypass_source < `GEN_COUNT; // R6

    always_ff @(posedge clk) begin
        if (srst) begin
            pci_out_q <= 1'b0;
        end else if (!hi_q.bypass_enable) begin
            pci_out_q <= local_out; // R4
        end else if (bypass_valid) begin
            pci_out_q <= bypass_in[hi_q.bypass_source[1:0]]; // R5
        end else begin
            pci_out_q <= 1'b0; // R6
        end
    end

    assign pci_out = pci_out_q;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_reset_zero;
        @(posedge clk) disable iff (1'b0) srst |=> (hi_q == 16'h0000) && (lo_q == 16'h0000);
    endproperty
    a_reset_zero: assert property (p_reset_zero) // R23
        else $error("fields not zero after reset");

    property p_term_reads_zero;
        psel && penable && !pwrite && hit_lo |-> prdata[`SOFTWARE_TERMINATION_BIT_POS] == 1'b0;
    endproperty
    a_term_reads_zero: assert property (p_term_reads_zero) // R17
        else $error("software termination bit read back as one");

    property p_term_pulse;
        wr_en && hit_lo && pstrb[0] && pwdata[`SOFTWARE_TERMINATION_BIT_POS] |=> term_write_q ##1 !term_write_q;
    endproperty
    a_term_pulse: assert property (p_term_pulse) // R17
        else $error("software termination did not pulse once");

    property p_source_zero;
        lo_q.source_selector == `SRC_ZERO |-> src_raw == 1'b0;
    endproperty
    a_source_zero: assert property (p_source_zero) // R1
        else $error("source code zero not tied low");

    property p_sync_hold;
        lo_q.source_sync && !eoc |=> $stable(src_hold_q);
    endproperty
    a_sync_hold: assert property (p_sync_hold) // R18
        else $error("synchronised source moved outside cycle end");

    property p_level_mode;
        hi_q.acceptance_criteria == ACC_LEVEL |=> local_out == $past(src_eff & aq);
    endproperty
    a_level_mode: assert property (p_level_mode) // R7
        else $error("level mode output mismatch");

    property p_bypass_pick;
        hi_q.bypass_enable && bypass_valid
        |=> pci_out == $past(bypass_in[hi_q.bypass_source[1:0]]);
    endproperty
    a_bypass_pick: assert property (p_bypass_pick) // R5
        else $error("bypass did not follow selected generator");

    property p_bypass_absent;
        hi_q.bypass_enable && !bypass_valid |=> !pci_out;
    endproperty
    a_bypass_absent: assert property (p_bypass_absent) // R6
        else $error("absent generator did not force zero");

    property p_no_bypass;
        !hi_q.bypass_enable |=> pci_out == $past(local_out);
    endproperty
    a_no_bypass: assert property (p_no_bypass) // R4
        else $error("local output not passed when bypass off");

    property p_sw_qual;
        lo_q.acceptance_qualifier_selector == `QUAL_SW_ONLY &&
        hi_q.software_control_mode == `SWM_AQUAL |-> aq == hi_q.software_control_bit;
    endproperty
    a_sw_qual: assert property (p_sw_qual) // R9
        else $error("software-only qualifier mismatch");

    property p_tq_forced_one;
        hi_q.termination_qualifier_selector == 3'h0 &&
        !hi_q.termination_qualifier_polarity |-> tq;
    endproperty
    a_tq_forced_one: assert property (p_tq_forced_one) // R12
        else $error("no termination qualifier did not force one");

    property p_term_at_eoc;
        hi_q.acceptance_criteria == ACC_LATCH && $stable(hi_q.acceptance_criteria) &&
        !$past(lo_q.termination_sync_disable) && $fell(local_out) |-> $past(eoc);
    endproperty
    a_term_at_eoc: assert property (p_term_at_eoc) // R13
        else $error("synchronised termination away from cycle end");

    c_bypass: cover property (hi_q.bypass_enable && pci_out);
    c_latched: cover property (hi_q.acceptance_criteria == ACC_LATCH && local_out);
    c_manual_term: cover property (term_write_q && local_out);
    c_auto_term: cover property (auto_term && $fell(src_eff));
endmodule

// >>> design/pci_latch_core.sv
// Acceptance criteria, set-reset latch and termination timing
`timescale 1ns/1ps
module pci_latch_core
    import pci_cond_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic eoc,
    input wire logic src,
    input wire logic aq,
    input wire logic tq,
    input wire logic term_evt,
    input wire logic auto_term,
    input wire logic [2:0] criteria,
    input wire logic reset_dominant,
    input wire logic sync_disable,
    output logic out_q
);
    latch_state_t state_q;
    latch_state_t state_d;
    logic src_prev_q;
    logic rise;
    logic edge_seen;
    logic set_c;
    logic term_now;
    logic fire;
    logic latched_mode;
    logic out_d;
    accept_crit_t crit;

    assign crit = accept_crit_t'(criteria);
    assign rise = src & ~src_prev_q;
    assign edge_seen = src ^ src_prev_q;
    assign latched_mode = (crit == ACC_LATCH) || (crit == ACC_LATCH_RISE) ||
                          (crit == ACC_LATCH_ANY);
    assign term_now = (term_evt | (auto_term & src_prev_q & ~src)) & tq; // R14 R22
    assign fire = sync_disable | eoc; // R13

    always_comb begin
        set_c = 1'b0;
        case (crit)
            ACC_LATCH: set_c = src & aq; // R7
            ACC_LATCH_RISE: set_c = rise & aq;
            ACC_LATCH_ANY: set_c = edge_seen & aq;
            default: set_c = 1'b0;
        endcase
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            LS_IDLE: begin
                // Reset-dominant latch stays clear while set and reset both stand
                if (set_c && !(term_now && reset_dominant)) state_d = LS_HELD; // R10
            end
            LS_HELD: begin
                if (term_now && !fire) begin
                    state_d = LS_WAIT; // R13
                end else if (term_now) begin
                    state_d = (set_c && !reset_dominant) ? LS_HELD : LS_IDLE; // R10
                end
            end
            LS_WAIT: begin
                if (fire) begin
                    state_d = (set_c && !reset_dominant) ? LS_HELD : LS_IDLE; // R10
                end
            end
            default: state_d = LS_IDLE;
        endcase
        if (!latched_mode) state_d = LS_IDLE;
    end

    always_comb begin
        case (crit)
            ACC_LEVEL: out_d = src & aq; // R7 R22
            ACC_RISE: out_d = rise & aq;
            ACC_ANY: out_d = edge_seen & aq;
            ACC_LATCH, ACC_LATCH_RISE, ACC_LATCH_ANY: out_d = (state_d != LS_IDLE);
            default: out_d = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= LS_IDLE;
            src_prev_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            state_q <= state_d;
            src_prev_q <= src;
            out_q <= out_d;
        end
    end

    property p_reset_dominant;
        @(posedge clk) disable iff (srst)
        (state_q != LS_IDLE) && latched_mode && term_now && fire && reset_dominant
        |=> !out_q;
    endproperty
    a_reset_dominant: assert property (p_reset_dominant) // R10
        else $error("reset-dominant latch stayed set");
endmodule

// >>> testbench/pwm_timing_model.sv
// Behavioural PWM generator timing that feeds the conditioner
`timescale 1ns/1ps
module pwm_timing_model #(
    parameter int PERIOD = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic run,
    output logic eoc,
    output logic duty_active,
    output logic blank_active,
    output logic gen_triggered
);
    logic [7:0] cnt_q;

    always_ff @(posedge clk) begin
        if (srst || !run) begin
            cnt_q <= 8'h00;
        end else if (cnt_q == 8'(PERIOD - 1)) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // Stopped generator: no cycle end, all phase flags high
    assign eoc = run && (cnt_q == 8'(PERIOD - 1));
    assign duty_active = cnt_q < 8'(PERIOD / 2);
    assign blank_active = cnt_q < 8'h02;
    assign gen_triggered = cnt_q == 8'h00;
endmodule

// >>> testbench/test_pci_conditioner.sv
// Self-checking bench for the PWM control input conditioner
`timescale 1ns/1ps
`include "pci_cond_consts.svh"
module test_pci_conditioner
    import pci_cond_pkg::*;
;
    logic clk = 1'h0;
    logic srst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [3:0] bypass_in = 4'h0;
    logic run = 1'h0;
    logic [31:0] prdata;
    logic pready, pslverr, local_out, pci_out, eoc, duty, blank, trig;
    pci_sources_t src_q = '0;
    pci_sources_t src_in;
    int error_cnt = 0;
    int n_tests = 0;

    always #5 clk = ~clk;

    always_comb begin
        src_in = src_q;
        src_in.duty_active = duty;
        src_in.blank_active = blank;
        src_in.gen_triggered = trig;
    end

    pci_conditioner u_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sources(src_in), .eoc(eoc),
        .bypass_in(bypass_in), .local_out(local_out), .pci_out(pci_out));

    pwm_timing_model #(.PERIOD(16)) u_gen (.clk(clk), .srst(srst), .run(run), .eoc(eoc),
        .duty_active(duty), .blank_active(blank), .gen_triggered(trig));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic bchk(string n, logic seen, logic exp);
        check(n, {31'h0, seen}, {31'h0, exp});
    endtask

    task automatic apb(logic w, logic [11:0] a, logic [15:0] d, logic [3:0] s,
                       output logic [31:0] rd, output logic err);
        int i;
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0, d};
        pstrb <= s;
        @(posedge clk);
        penable <= 1'h1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'h1 && i < 20);
        if (i >= 20) begin
            error_cnt++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(logic [11:0] a, logic [15:0] d);
        logic [31:0] r;
        logic x;
        apb(1'h1, a, d, 4'h3, r, x);
    endtask

    task automatic rd_chk(string n, logic [11:0] a, logic [31:0] exp);
        logic [31:0] r;
        logic x;
        apb(1'h0, a, 16'h0, 4'h0, r, x);
        check(n, r, exp);
    endtask

    // Output settles one cycle after the field, the final stage one more
    task automatic out_chk(string n, logic e);
        repeat (4) @(posedge clk);
        bchk(n, local_out, e);
        bchk(n, pci_out, e);
    endtask

    task automatic setsrc(pci_sources_t v);
        @(posedge clk);
        src_q <= v;
    endtask

    task automatic run_to_eoc();
        int i;
        run <= 1'h1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (eoc !== 1'h1 && i < 100);
        if (i >= 100) begin
            error_cnt++;
            finish_test();
        end
        // Let the design sample the cycle-end pulse before stopping
        @(posedge clk);
        run <= 1'h0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pci_sources_t s;
        logic [31:0] r;
        logic er;
        logic e;
        logic [5:0] tv;
        repeat (8) @(posedge clk);
        srst <= 1'h0;
        rd_chk("accept_high reset", `ACCEPT_HIGH_ADDR, 32'h0);
        rd_chk("select_low reset", `SELECT_LOW_ADDR, 32'h0);
        out_chk("reset out", 1'h0);
        apb(1'h1, 12'h100, 16'hFFFF, 4'h3, r, er);
        bchk("unmapped write err", er, 1'h1);
        apb(1'h0, 12'h100, 16'h0, 4'h0, r, er);
        check("unmapped read", r, 32'h0);
        apb(1'h1, `ACCEPT_HIGH_ADDR, 16'hFFFF, 4'h1, r, er);
        bchk("mapped err", er, 1'h0);
        rd_chk("low lane", `ACCEPT_HIGH_ADDR, 32'h00FF);
        wr(`ACCEPT_HIGH_ADDR, 16'hFFFF);
        rd_chk("accept_high all", `ACCEPT_HIGH_ADDR, 32'hF7FF);
        wr(`SELECT_LOW_ADDR, 16'hFFFF);
        rd_chk("select_low all", `SELECT_LOW_ADDR, 32'hFF7F);
        wr(`ACCEPT_HIGH_ADDR, 16'h0000);
        // Every source code, both polarities
        for (int c = 0; c < 64; c++) begin
            s = '0;
            e = 1'h1;
            case (c[4:0]) inside
                5'h01: s.gen_out_mux = 1'h1;
                5'h02: s.trigger_a = 1'h1;
                5'h03: s.trigger_b = 1'h1;
                [5'h08:5'h12]: s.remap[c[4:0]] = 1'h1;
                [5'h13:5'h16]: s.pins[c[4:0]] = 1'h1;
                [5'h17:5'h1A]: s.events[c[4:0]] = 1'h1;
                [5'h1B:5'h1D]: s.comparators[c[4:0]] = 1'h1;
                5'h1F: s.clc_one = 1'h1;
                default: begin
                    s = '1;
                    e = 1'h0;
                end
            endcase
            setsrc(s);
            wr(`SELECT_LOW_ADDR, {10'h0, c[5], c[4:0]});
            out_chk("source route", e ^ c[5]);
        end
        // Every acceptance qualifier code, both polarities
        for (int q = 0; q < 16; q++) begin
            s = '0;
            s.pins[19] = 1'h1;
            s.gen_out_mux = q[2:0] != 3'h4;
            s.remap[8] = q[2:0] != 3'h5;
            s.remap[9] = q[2:0] != 3'h6;
            setsrc(s);
            wr(`SELECT_LOW_ADDR, {4'h0, q[3], q[2:0], 8'h13});
            e = (q[2:0] == 3'h7) ? 1'h0 : ((q[2:0] < 3'h4) ^ q[3]);
            out_chk("accept qualifier", e);
        end
        wr(`ACCEPT_HIGH_ADDR, 16'h00A0);
        out_chk("sw to qualifier", 1'h1);
        wr(`ACCEPT_HIGH_ADDR, 16'h00E0);
        out_chk("sw reserved mode", 1'h0);
        wr(`SELECT_LOW_ADDR, 16'h0000);
        wr(`ACCEPT_HIGH_ADDR, 16'h0080);
        out_chk("sw to accept", 1'h1);
        wr(`ACCEPT_HIGH_ADDR, 16'h0680);
        out_chk("reserved criteria", 1'h0);
        // Every termination event code on a latched input
        for (int t = 0; t < 8; t++) begin
            s = '0;
            s.pins[19] = 1'h1;
            setsrc(s);
            wr(`ACCEPT_HIGH_ADDR, 16'h0300);
            wr(`SELECT_LOW_ADDR, {1'h1, t[2:0], 12'h013});
            out_chk("latch set", 1'h1);
            tv = (t < 2) ? 6'h3F : (6'h3F ^ (6'h01 << (t - 2)));
            s = '0;
            {s.remap[9], s.remap[8], s.gen_out_mux, s.trigger_c, s.trigger_b, s.trigger_a} = tv;
            setsrc(s);
            out_chk("latch hold", t != 1);
            if (t == 0) begin
                wr(`SELECT_LOW_ADDR, 16'h8093);
            end
            s.gen_out_mux = 1'h1;
            {s.remap[9], s.remap[8], s.trigger_c, s.trigger_b, s.trigger_a} = 5'h1F;
            setsrc(s);
            out_chk("latch clear", 1'h0);
        end
        s = '0;
        s.pins[19] = 1'h1;
        s.trigger_a = 1'h1;
        setsrc(s);
        wr(`SELECT_LOW_ADDR, 16'hA013);
        wr(`ACCEPT_HIGH_ADDR, 16'h0310);
        out_chk("reset dominant", 1'h0);
        wr(`ACCEPT_HIGH_ADDR, 16'h0300);
        out_chk("set dominant", 1'h1);
        s.pins[19] = 1'h0;
        wr(`ACCEPT_HIGH_ADDR, 16'h0308);
        setsrc(s);
        out_chk("tq inverted", 1'h1);
        wr(`ACCEPT_HIGH_ADDR, 16'h0307);
        out_chk("tq sw zero", 1'h1);
        wr(`ACCEPT_HIGH_ADDR, 16'h03C7);
        out_chk("tq sw one", 1'h0);
        // Termination deferred to cycle end, then source sync
        s = '0;
        s.pins[19] = 1'h1;
        setsrc(s);
        wr(`SELECT_LOW_ADDR, 16'h0013);
        wr(`ACCEPT_HIGH_ADDR, 16'h0300);
        out_chk("deferred set", 1'h1);
        s.pins[19] = 1'h0;
        setsrc(s);
        wr(`SELECT_LOW_ADDR, 16'h0093);
        out_chk("deferred hold", 1'h1);
        run_to_eoc();
        out_chk("deferred end", 1'h0);
        wr(`ACCEPT_HIGH_ADDR, 16'h0000);
        wr(`SELECT_LOW_ADDR, 16'h0053);
        s.pins[19] = 1'h1;
        setsrc(s);
        out_chk("sync hold", 1'h0);
        run_to_eoc();
        out_chk("sync taken", 1'h1);
        wr(`SELECT_LOW_ADDR, 16'h0000);
        // Bypass from every generator code
        for (int b = 0; b < 8; b++) begin
            wr(`ACCEPT_HIGH_ADDR, {1'h1, b[2:0], 12'h000});
            bypass_in <= 4'hF ^ (4'h1 << b);
            repeat (4) @(posedge clk);
            bchk("bypass other", pci_out, 1'h0);
            bypass_in <= 4'h1 << b;
            repeat (4) @(posedge clk);
            bchk("bypass chosen", pci_out, b < 4);
        end
        finish_test();
    end
endmodule
